//--- dv/test_accumulator_transfer_ops.sv
module test_accumulator_transfer_ops
  import ato_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic instr_valid = 1'b0;
  logic [ATO_OPC_W-1:0] opcode = 10'h000;
  logic ext_acc_we = 1'b0;
  logic [3:0] ext_acc_data = 4'h0;
  logic ext_regb_we = 1'b0;
  logic [3:0] ext_regb_data = 4'h0;
  logic carry_in = 1'b0;
  logic [7:0] first_timer_count = 8'h00;
  logic [7:0] second_timer_count = 8'h00;
  logic [9:0] conversion_result = 10'h000;
  logic [3:0] converter_control_register = 4'h0;
  logic [3:0] acc_q;
  logic [3:0] regb_q;
  logic carry_q;
  logic skip_next_q;
  logic xfer_done_q;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;

  ato_transfer_ops dut (.clk_sys(clk_sys), .rst_n(rst_n), .instr_valid(instr_valid),
    .opcode(opcode), .ext_acc_we(ext_acc_we), .ext_acc_data(ext_acc_data),
    .ext_regb_we(ext_regb_we), .ext_regb_data(ext_regb_data), .carry_in(carry_in),
    .first_timer_count(first_timer_count), .second_timer_count(second_timer_count),
    .conversion_result(conversion_result),
    .converter_control_register(converter_control_register), .acc_q(acc_q),
    .regb_q(regb_q), .carry_q(carry_q), .skip_next_q(skip_next_q),
    .xfer_done_q(xfer_done_q));

  always #2 clk_sys = ~clk_sys;

  task automatic summarize();
    if (fail_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // A hung run is cut short well past the few dozen cycles the scenarios need.
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      fail_count++;
      summarize();
    end
  end

  task automatic chk_nib(input string name, input logic [3:0] exp, input logic [3:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic run(input logic [9:0] op, input logic c);
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    opcode <= op;
    carry_in <= c;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
  endtask

  task automatic check_ab(input logic [3:0] b, input logic [3:0] a, input logic done);
    chk_nib("regb_q", b, regb_q);
    chk_nib("acc_q", a, acc_q);
    chk_bit("xfer_done_q", done, xfer_done_q);
    chk_bit("skip_next_q", 1'b0, skip_next_q);
  endtask

  task automatic copy_test();
    @(posedge clk_sys);
    ext_acc_we <= 1'b1;
    ext_acc_data <= 4'h3;
    ext_regb_we <= 1'b1;
    ext_regb_data <= 4'hc;
    @(posedge clk_sys);
    ext_acc_we <= 1'b0;
    ext_regb_we <= 1'b0;
    #1;
    check_ab(4'hc, 4'h3, 1'b0);
    run(ATO_OPC_COPY_B_TO_A, 1'b1);
    check_ab(4'hc, 4'hc, 1'b1);
    chk_bit("carry_q", 1'b1, carry_q);
  endtask

  // Back to back so a design that needs two cycles per transfer shows it.
  task automatic timer_test();
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    opcode <= ATO_OPC_READ_FIRST_TIMER;
    first_timer_count <= 8'h3c;
    second_timer_count <= 8'hd7;
    @(posedge clk_sys);
    opcode <= ATO_OPC_READ_SECOND_TIMER;
    first_timer_count <= 8'hff;
    #1;
    check_ab(4'h3, 4'hc, 1'b1);
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
    check_ab(4'hd, 4'h7, 1'b1);
    @(posedge clk_sys);
    #1;
    chk_bit("xfer_done_q", 1'b0, xfer_done_q);
  endtask

  // Other control bits are set opposite to bit 3 to catch a wrong bit pick.
  task automatic result_test(input logic [3:0] ctrl, input logic [3:0] b, input logic [3:0] a);
    @(posedge clk_sys);
    conversion_result <= 10'h2d6;
    converter_control_register <= ctrl;
    run(ATO_OPC_READ_CONVERSION_RESULT, 1'b0);
    check_ab(b, a, 1'b1);
    chk_bit("carry_q", 1'b0, carry_q);
  endtask

  task automatic clash_test();
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    opcode <= ATO_OPC_READ_FIRST_TIMER;
    first_timer_count <= 8'h96;
    ext_acc_we <= 1'b1;
    ext_acc_data <= 4'h1;
    ext_regb_we <= 1'b1;
    ext_regb_data <= 4'h2;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    ext_acc_we <= 1'b0;
    ext_regb_we <= 1'b0;
    #1;
    check_ab(4'h9, 4'h6, 1'b1);
    run(10'h27a, 1'b0);
    check_ab(4'h9, 4'h6, 1'b0);
  endtask

  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    check_ab(4'h0, 4'h0, 1'b0);
    copy_test();
    timer_test();
    result_test(4'h7, 4'hb, 4'h5);
    result_test(4'h8, 4'hd, 4'h6);
    clash_test();
    summarize();
  end
endmodule

//--- hw/ato_decode.sv
module ato_decode
  import ato_pkg::*;
(
  input wire logic instr_valid,
  input wire logic [ATO_OPC_W-1:0] opcode,
  output ato_op_t op
);

  // Words outside the four transfers decode to no operation here.
  always_comb
  begin
    op = ATO_OP_NONE;
    if (instr_valid)
    begin
      case (opcode)
        ATO_OPC_COPY_B_TO_A: op = ATO_OP_COPY_B_TO_A;
        ATO_OPC_READ_FIRST_TIMER: op = ATO_OP_READ_FIRST_TIMER;
        ATO_OPC_READ_SECOND_TIMER: op = ATO_OP_READ_SECOND_TIMER;
        ATO_OPC_READ_CONVERSION_RESULT: op = ATO_OP_READ_CONVERSION_RESULT;
        default: op = ATO_OP_NONE;
      endcase
    end
  end

endmodule

//--- hw/ato_pkg.sv
package ato_pkg;

  localparam int ATO_NIB_W = 4;
  localparam int ATO_TMR_W = 8;
  localparam int ATO_ADC_W = 10;
  localparam int ATO_OPC_W = 10;
  localparam int ATO_CTRL_W = 4;

  // Instruction words of the four transfers.
  localparam logic [9:0] ATO_OPC_COPY_B_TO_A = 10'h01e;
  localparam logic [9:0] ATO_OPC_READ_FIRST_TIMER = 10'h270;
  localparam logic [9:0] ATO_OPC_READ_SECOND_TIMER = 10'h271;
  localparam logic [9:0] ATO_OPC_READ_CONVERSION_RESULT = 10'h279;

  // Bit of the converter control register that picks the result mapping.
  localparam int ATO_COMPARATOR_MODE_SELECT_BIT = 3;

  // Field positions (low bit of each nibble).
  localparam int ATO_TMR_HI_LSB = 4;
  localparam int ATO_TMR_LO_LSB = 0;
  localparam int ATO_ADC_CONV_HI_LSB = 6;
  localparam int ATO_ADC_CONV_LO_LSB = 2;
  localparam int ATO_ADC_CMP_HI_LSB = 4;
  localparam int ATO_ADC_CMP_LO_LSB = 0;

  // Every transfer takes one word and one instruction cycle.
  localparam int ATO_WORDS = 1;
  localparam int ATO_CYCLES = 1;

  localparam logic [3:0] ATO_RST_NIB = 4'h0;

  typedef enum logic [2:0] {
    ATO_OP_NONE,
    ATO_OP_COPY_B_TO_A,
    ATO_OP_READ_FIRST_TIMER,
    ATO_OP_READ_SECOND_TIMER,
    ATO_OP_READ_CONVERSION_RESULT
  } ato_op_t;

endpackage

//--- hw/ato_transfer_ops.sv
// Operation
// - Copy instruction loads accumulator from register B; B keeps its value.
// - First-timer read: B gets timer bits 7-4, accumulator bits 3-0.
// - Second-timer read: B gets timer bits 7-4, accumulator bits 3-0.
// - Result read in conversion mode: B gets bits 9-6, accumulator 5-2.
// - Result read in comparator mode: B gets bits 7-4, accumulator 3-0.
// - Control register bit 3 picks the mode: 0 conversion, 1 comparator.
module ato_transfer_ops
  import ato_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [ATO_OPC_W-1:0] opcode,
  input wire logic ext_acc_we,
  input wire logic [ATO_NIB_W-1:0] ext_acc_data,
  input wire logic ext_regb_we,
  input wire logic [ATO_NIB_W-1:0] ext_regb_data,
  input wire logic carry_in,
  input wire logic [ATO_TMR_W-1:0] first_timer_count,
  input wire logic [ATO_TMR_W-1:0] second_timer_count,
  input wire logic [ATO_ADC_W-1:0] conversion_result,
  input wire logic [ATO_CTRL_W-1:0] converter_control_register,
  output logic [ATO_NIB_W-1:0] acc_q,
  output logic [ATO_NIB_W-1:0] regb_q,
  output logic carry_q,
  output logic skip_next_q,
  output logic xfer_done_q
);

  ato_op_t op;
  logic comparator_mode_select;
  logic xfer_hit;
  logic [ATO_NIB_W-1:0] acc_d;
  logic [ATO_NIB_W-1:0] regb_d;

  ato_decode u_decode (
    .instr_valid(instr_valid),
    .opcode(opcode),
    .op(op)
  );

  assign comparator_mode_select =
    converter_control_register[ATO_COMPARATOR_MODE_SELECT_BIT];
  assign xfer_hit = (op != ATO_OP_NONE);

  // The transfer decides both nibbles from the sources as they stand in this cycle,
  // so a timer that counts in the same cycle is read at its old value.
  always_comb
  begin
    acc_d = acc_q;
    regb_d = regb_q;
    if (ext_acc_we)
    begin
      acc_d = ext_acc_data;
    end
    if (ext_regb_we)
    begin
      regb_d = ext_regb_data;
    end
    case (op)
      ATO_OP_NONE:
      begin
      end
      ATO_OP_COPY_B_TO_A:
      begin
        acc_d = regb_q;
        regb_d = regb_q;
      end
      ATO_OP_READ_FIRST_TIMER:
      begin
        regb_d = first_timer_count[ATO_TMR_HI_LSB +: ATO_NIB_W];
        acc_d = first_timer_count[ATO_TMR_LO_LSB +: ATO_NIB_W];
      end
      ATO_OP_READ_SECOND_TIMER:
      begin
        regb_d = second_timer_count[ATO_TMR_HI_LSB +: ATO_NIB_W];
        acc_d = second_timer_count[ATO_TMR_LO_LSB +: ATO_NIB_W];
      end
      ATO_OP_READ_CONVERSION_RESULT:
      begin
        if (comparator_mode_select)
        begin
          regb_d = conversion_result[ATO_ADC_CMP_HI_LSB +: ATO_NIB_W];
          acc_d = conversion_result[ATO_ADC_CMP_LO_LSB +: ATO_NIB_W];
        end
        else
        begin
          regb_d = conversion_result[ATO_ADC_CONV_HI_LSB +: ATO_NIB_W];
          acc_d = conversion_result[ATO_ADC_CONV_LO_LSB +: ATO_NIB_W];
        end
      end
      default:
      begin
        acc_d = acc_q;
        regb_d = regb_q;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_q <= ATO_RST_NIB;
      regb_q <= ATO_RST_NIB;
    end
    else
    begin
      acc_q <= acc_d;
      regb_q <= regb_d;
    end
  end

  // Carry simply follows the core; none of these transfers writes it.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      carry_q <= 1'b0;
    end
    else
    begin
      carry_q <= carry_in;
    end
  end

  // Skip is held low because no transfer here ever skips; kept as a port so the
  // sequencer can merge it with the skip outputs of other groups.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      skip_next_q <= 1'b0;
      xfer_done_q <= 1'b0;
    end
    else
    begin
      skip_next_q <= 1'b0;
      xfer_done_q <= xfer_hit;
    end
  end

  // Checks.

  AST_COPY_LOADS_ACC: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op == ATO_OP_COPY_B_TO_A |=> acc_q == $past(regb_q) && regb_q == $past(regb_q)
  ) else $error("copy did not move register B into the accumulator");

  AST_FIRST_TIMER_READ: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op == ATO_OP_READ_FIRST_TIMER |=>
      {regb_q, acc_q} == $past(first_timer_count)
  ) else $error("first timer read gave wrong nibbles");

  AST_SECOND_TIMER_READ: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op == ATO_OP_READ_SECOND_TIMER |=>
      {regb_q, acc_q} == $past(second_timer_count)
  ) else $error("second timer read gave wrong nibbles");

  AST_RESULT_CONV_MODE: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op == ATO_OP_READ_CONVERSION_RESULT && !converter_control_register[3] |=>
      {regb_q, acc_q} == $past(conversion_result[9:2])
  ) else $error("conversion mode result read gave wrong nibbles");

  AST_RESULT_CMP_MODE: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    op == ATO_OP_READ_CONVERSION_RESULT && converter_control_register[3] |=>
      {regb_q, acc_q} == $past(conversion_result[7:0])
  ) else $error("comparator mode result read gave wrong nibbles");

  AST_MODE_BIT_SELECTS: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    instr_valid && opcode == ATO_OPC_READ_CONVERSION_RESULT |=>
      acc_q == ($past(converter_control_register[ATO_COMPARATOR_MODE_SELECT_BIT]) ?
      $past(conversion_result[3:0]) : $past(conversion_result[5:2]))
  ) else $error("result mapping not picked by control bit 3");

  // These two look at the raw word, so a broken decoder cannot hide behind op.
  AST_DECODE_HITS: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    instr_valid && (opcode == ATO_OPC_COPY_B_TO_A || opcode == ATO_OPC_READ_FIRST_TIMER ||
      opcode == ATO_OPC_READ_SECOND_TIMER || opcode == ATO_OPC_READ_CONVERSION_RESULT) |=>
      xfer_done_q
  ) else $error("transfer word did not complete in one cycle");

  AST_OTHER_WORDS_IGNORED: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !(instr_valid && (opcode == ATO_OPC_COPY_B_TO_A || opcode == ATO_OPC_READ_FIRST_TIMER ||
      opcode == ATO_OPC_READ_SECOND_TIMER || opcode == ATO_OPC_READ_CONVERSION_RESULT)) |=>
      !xfer_done_q
  ) else $error("done pulse for a word that is not one of the transfers");

  AST_NEVER_SKIPS: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    xfer_hit |=> !skip_next_q && xfer_done_q && carry_q == $past(carry_in)
  ) else $error("transfer skipped, lost carry or took more than one cycle");

  AST_DONE_ONE_CYCLE: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    xfer_done_q |-> $past(xfer_hit)
  ) else $error("done pulse without a transfer in the previous cycle");

  AST_IDLE_HOLDS: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !xfer_hit && !ext_acc_we && !ext_regb_we |=> $stable(acc_q) && $stable(regb_q)
  ) else $error("registers moved with no instruction");

  COV_COPY: cover property (
    @(posedge clk_sys) disable iff (!rst_n)
    op == ATO_OP_COPY_B_TO_A
  );

  COV_TIMERS_BACK_TO_BACK: cover property (
    @(posedge clk_sys) disable iff (!rst_n)
    op == ATO_OP_READ_FIRST_TIMER ##1 op == ATO_OP_READ_SECOND_TIMER
  );

  COV_RESULT_CONV: cover property (
    @(posedge clk_sys) disable iff (!rst_n)
    op == ATO_OP_READ_CONVERSION_RESULT && !comparator_mode_select
  );

  COV_RESULT_CMP: cover property (
    @(posedge clk_sys) disable iff (!rst_n)
    op == ATO_OP_READ_CONVERSION_RESULT && comparator_mode_select
  );

endmodule
